// >>> design/pamx_map.vh
// offsets, field layouts, reset values and mode codes of the port a mux
`ifndef PAMX_MAP_VH
`define PAMX_MAP_VH

// -------------------------------------------------------------
// register offsets (byte addresses, one word each)
// -------------------------------------------------------------
`define PAMX_OFS_PIN_LEVEL 5'h00
`define PAMX_OFS_OUT_LATCH 5'h04
`define PAMX_OFS_DIRECTION 5'h08
`define PAMX_OFS_ANALOG    5'h0C
`define PAMX_OFS_SLEW      5'h10
`define PAMX_OFS_STATUS    5'h14

// -------------------------------------------------------------
// implemented bits and reset values
// -------------------------------------------------------------
`define PAMX_ANALOG_MASK   8'h2F
`define PAMX_SLEW_MASK     8'h1F
`define PAMX_RST_LATCH     8'h00
`define PAMX_RST_DIRECTION 8'hFF
`define PAMX_RST_ANALOG    8'h2F
`define PAMX_RST_SLEW      8'h00

// -------------------------------------------------------------
// status register fields
// -------------------------------------------------------------
`define PAMX_ST_MODE_LSB   0
`define PAMX_ST_CLKOUT_BIT 4
`define PAMX_ST_VALID_BIT  5

// -------------------------------------------------------------
// oscillator select field codes
// -------------------------------------------------------------
`define PAMX_OSC_CRYSTAL   4'h0
`define PAMX_OSC_RC        4'h1
`define PAMX_OSC_EXTCLK    4'h2
`define PAMX_OSC_INTERNAL_OSCILLATOR_MODE    4'h3

// clock-out counter end value and half period in system clocks (period four, quarter rate)
`define PAMX_CLKOUT_DIV    2'h3
`define PAMX_CLKOUT_HALF   2'h2

`endif

// >>> design/pamx_pin_mux.v
// one pin's output priority selector: three sources, then the latch
`timescale 1ns/1ns
`default_nettype none

module pamx_pin_mux (
   input  wire [2:0] i_src_en,
   input  wire [2:0] i_src_val,
   input  wire       i_latch,
   input  wire       i_dir,
   input  wire       i_force_en,
   input  wire       i_force_val,
   input  wire       i_blocked,
   output reg        o_val,
   output reg        o_oe
);

   // ----------------------------------------------------------
   // priority: blocked, then force, then bit 2 down to bit 0, then latch
   // ----------------------------------------------------------
   always @* begin
      o_val = i_latch;
      o_oe  = ~i_dir;
      if (i_blocked) begin
         o_val = 1'b0;
         o_oe  = 1'b0;
      end else if (i_force_en) begin
         // drives whatever the direction bit says
         o_val = i_force_val;
         o_oe  = 1'b1;
      end else if (i_src_en[2]) begin
         o_val = i_src_val[2];
      end else if (i_src_en[1]) begin
         o_val = i_src_val[1];
      end else if (i_src_en[0]) begin
         o_val = i_src_val[0];
      end
   end

endmodule

`default_nettype wire

// >>> design/pamx_top.v
// port a pin function priority mux with its avalon register file
//
// Operation
// - internal_oscillator_mode pin six io only without clock-out
// - rc mode drives quarter-rate clock-out on six
// - external osc modes kill pin seven digital paths
// - external clock input always uses pin seven
// - highest-priority enabled function owns the pin
// - analog inputs active only when analog selected
// - digital outputs still drive analog-mode pins
// - fixed per-bit priority order for pins 4-7
// - unimplemented register bits read zero
// - analog select disables digital input only
// - analog pins read zero through pin level
//
// The register offsets and the Avalon-MM register port are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "pamx_map.vh"

module pamx_top (
   input  wire        i_clk_sys,
   input  wire        i_nrst,
   // avalon-mm slave
   input  wire [4:0]  i_avs_address,
   input  wire        i_avs_read,
   input  wire        i_avs_write,
   input  wire [31:0] i_avs_writedata,
   output wire [31:0] o_avs_readdata,
   output wire        o_avs_waitrequest,
   // static configuration straps
   input  wire [3:0]  i_osc_select_field,
   input  wire        i_clkout_strap,
   // peripheral sources
   input  wire        i_sr_latch_true_output,
   input  wire        i_sr_true_en,
   input  wire        i_sr_latch_inverted_output,
   input  wire        i_sr_inv_en,
   input  wire        i_comparator_one_output,
   input  wire        i_cmp1_en,
   input  wire        i_comparator_two_output,
   input  wire        i_cmp2_en,
   input  wire        i_capture_compare_five,
   input  wire        i_capture_compare_five_en,
   // package pins
   input  wire [7:0]  i_pin_in,
   output wire [7:0]  o_pin_out,
   output wire [7:0]  o_pin_oe,
   output wire [7:0]  o_analog_en,
   output wire [4:0]  o_slew_limit,
   output wire        o_crystal_input_function,
   output wire        o_crystal_output_function,
   output wire        o_external_clock_in_function
);

   // ----------------------------------------------------------
   // registers
   // ----------------------------------------------------------
   reg  [7:0]  output_latch_a_q;
   reg  [7:0]  direction_a_q;
   reg  [7:0]  analog_select_a_q;
   reg  [7:0]  slew_rate_control_q;
   reg  [3:0]  osc_mode_q;
   reg         clkout_en_q;
   reg         strap_done_q;
   reg         waitreq_q;
   reg  [31:0] readdata_q;
   reg  [1:0]  clk_div_q;
   reg         clkout_q;
   reg  [7:0]  pin_out_q;
   reg  [7:0]  pin_oe_q;
   reg         xtal_in_q;
   reg         xtal_out_q;
   reg         ext_clk_q;
   reg  [7:0]  rd_d;
   wire        req;
   wire        ack;
   wire [7:0]  pin_val;
   wire [7:0]  pin_oe;
   wire [7:0]  in_en;
   wire [7:0]  pin_level;

   // ----------------------------------------------------------
   // oscillator mode decode
   // ----------------------------------------------------------
   wire mode_xtal = (osc_mode_q == `PAMX_OSC_CRYSTAL);
   wire mode_rc   = (osc_mode_q == `PAMX_OSC_RC);
   // external clock and unlisted codes fall out of the two below
   wire mode_int  = (osc_mode_q == `PAMX_OSC_INTERNAL_OSCILLATOR_MODE);
   // pin seven belongs to the oscillator in every external mode
   wire pin7_osc  = ~mode_int;
   // pin six: crystal output, forced clock-out, or plain io
   wire pin6_clock_out_function = mode_rc | (~mode_xtal & clkout_en_q);
   wire pin6_io   = mode_int & ~clkout_en_q;

   // ----------------------------------------------------------
   // strap capture after reset release
   // ----------------------------------------------------------
   // async reset loads constants; the strap level is taken on
   // the first clock edge after release
   always @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         osc_mode_q   <= `PAMX_OSC_INTERNAL_OSCILLATOR_MODE;
         clkout_en_q  <= 1'b0;
         strap_done_q <= 1'b0;
      end else if (!strap_done_q) begin
         osc_mode_q   <= i_osc_select_field;
         clkout_en_q  <= i_clkout_strap;
         strap_done_q <= 1'b1;
      end
   end

   // ----------------------------------------------------------
   // quarter-rate clock-out
   // ----------------------------------------------------------
   always @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         clk_div_q <= 2'h0;
         clkout_q  <= 1'b0;
      end else begin
         clk_div_q <= clk_div_q + 2'h1;
         // high for two of every four system clocks
         clkout_q  <= (clk_div_q == `PAMX_CLKOUT_DIV) |
                      (clk_div_q < `PAMX_CLKOUT_HALF - 2'h1);
      end
   end

   // ----------------------------------------------------------
   // per-pin output priority
   // ----------------------------------------------------------
   // pins 0..3 carry only the latch
   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1) begin : g_plain
         pamx_pin_mux u_mux (
            .i_src_en    (3'h0),
            .i_src_val   (3'h0),
            .i_latch     (output_latch_a_q[g]),
            .i_dir       (direction_a_q[g]),
            .i_force_en  (1'b0),
            .i_force_val (1'b0),
            .i_blocked   (1'b0),
            .o_val       (pin_val[g]),
            .o_oe        (pin_oe[g])
         );
      end
   endgenerate

   // sr q, comparator one, capture_compare_five, latch
   pamx_pin_mux u_mux4 (
      .i_src_en    ({i_sr_true_en, i_cmp1_en, i_capture_compare_five_en}),
      .i_src_val   ({i_sr_latch_true_output,
                     i_comparator_one_output,
                     i_capture_compare_five}),
      .i_latch     (output_latch_a_q[4]),
      .i_dir       (direction_a_q[4]),
      .i_force_en  (1'b0),
      .i_force_val (1'b0),
      .i_blocked   (1'b0),
      .o_val       (pin_val[4]),
      .o_oe        (pin_oe[4])
   );

   // sr inverted q, comparator two, latch
   pamx_pin_mux u_mux5 (
      .i_src_en    ({i_sr_inv_en, i_cmp2_en, 1'b0}),
      .i_src_val   ({i_sr_latch_inverted_output,
                     i_comparator_two_output, 1'b0}),
      .i_latch     (output_latch_a_q[5]),
      .i_dir       (direction_a_q[5]),
      .i_force_en  (1'b0),
      .i_force_val (1'b0),
      .i_blocked   (1'b0),
      .o_val       (pin_val[5]),
      .o_oe        (pin_oe[5])
   );

   // crystal output, clock-out, latch
   pamx_pin_mux u_mux6 (
      .i_src_en    (3'h0),
      .i_src_val   (3'h0),
      .i_latch     (output_latch_a_q[6]),
      .i_dir       (direction_a_q[6]),
      .i_force_en  (pin6_clock_out_function),
      .i_force_val (clkout_q),
      .i_blocked   (mode_xtal | ~(pin6_io | pin6_clock_out_function)),
      .o_val       (pin_val[6]),
      .o_oe        (pin_oe[6])
   );

   // crystal input, latch
   pamx_pin_mux u_mux7 (
      .i_src_en    (3'h0),
      .i_src_val   (3'h0),
      .i_latch     (output_latch_a_q[7]),
      .i_dir       (direction_a_q[7]),
      .i_force_en  (1'b0),
      .i_force_val (1'b0),
      .i_blocked   (pin7_osc),
      .o_val       (pin_val[7]),
      .o_oe        (pin_oe[7])
   );

   // ----------------------------------------------------------
   // digital input enables and pin read-back
   // ----------------------------------------------------------
   // analog select gates only the input side; outputs above are
   // left alone so a peripheral can still drive an analog pin
   assign in_en[5:0] = ~analog_select_a_q[5:0];
   assign in_en[6]   = pin6_io;
   assign in_en[7]   = ~pin7_osc;
   assign pin_level  = i_pin_in & in_en;

   always @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         pin_out_q  <= 8'h00;
         pin_oe_q   <= 8'h00;
         xtal_in_q  <= 1'b0;
         xtal_out_q <= 1'b0;
         ext_clk_q  <= 1'b0;
      end else begin
         pin_out_q  <= pin_val;
         pin_oe_q   <= pin_oe;
         xtal_in_q  <= pin7_osc;
         xtal_out_q <= mode_xtal;
         // follows pin seven whatever its direction bit holds
         ext_clk_q  <= pin7_osc & i_pin_in[7];
      end
   end

   // ----------------------------------------------------------
   // avalon-mm slave: one wait cycle, then answer
   // ----------------------------------------------------------
   assign req = i_avs_read | i_avs_write;
   assign ack = req & ~waitreq_q;

   always @* begin
      case (i_avs_address)
         `PAMX_OFS_PIN_LEVEL: rd_d = pin_level;
         `PAMX_OFS_OUT_LATCH: rd_d = output_latch_a_q;
         `PAMX_OFS_DIRECTION: rd_d = direction_a_q;
         `PAMX_OFS_ANALOG:    rd_d = analog_select_a_q;
         `PAMX_OFS_SLEW:      rd_d = slew_rate_control_q;
         `PAMX_OFS_STATUS:    rd_d = {2'h0, strap_done_q, clkout_en_q,
                                      osc_mode_q};
         default:             rd_d = 8'h00;
      endcase
   end

   always @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         waitreq_q           <= 1'b1;
         readdata_q          <= 32'h0000_0000;
         output_latch_a_q    <= `PAMX_RST_LATCH;
         direction_a_q       <= `PAMX_RST_DIRECTION;
         analog_select_a_q   <= `PAMX_RST_ANALOG;
         slew_rate_control_q <= `PAMX_RST_SLEW;
      end else begin
         waitreq_q <= ~(req & waitreq_q);
         if (req & waitreq_q) begin
            readdata_q <= {24'h00_0000, rd_d};
         end
         if (ack & i_avs_write) begin
            case (i_avs_address)
               // a write to the pin level lands in the latch
               `PAMX_OFS_PIN_LEVEL,
               `PAMX_OFS_OUT_LATCH: begin
                  output_latch_a_q <= i_avs_writedata[7:0];
               end
               `PAMX_OFS_DIRECTION: begin
                  direction_a_q <= i_avs_writedata[7:0];
               end
               `PAMX_OFS_ANALOG: begin
                  analog_select_a_q <= i_avs_writedata[7:0] &
                                       `PAMX_ANALOG_MASK;
               end
               `PAMX_OFS_SLEW: begin
                  slew_rate_control_q <= i_avs_writedata[7:0] &
                                         `PAMX_SLEW_MASK;
               end
               default: begin
               end
            endcase
         end
      end
   end

   // ----------------------------------------------------------
   // outputs
   // ----------------------------------------------------------
   assign o_avs_readdata               = readdata_q;
   assign o_avs_waitrequest            = waitreq_q;
   assign o_pin_out                    = pin_out_q;
   assign o_pin_oe                     = pin_oe_q;
   assign o_analog_en                  = analog_select_a_q;
   assign o_slew_limit                 = slew_rate_control_q[4:0];
   assign o_crystal_input_function     = xtal_in_q;
   assign o_crystal_output_function    = xtal_out_q;
   assign o_external_clock_in_function = ext_clk_q;

endmodule

`default_nettype wire

// >>> verification/pamx_top_chk.sv
// assertions on the port a mux pins and register bus
`timescale 1ns/1ns
`default_nettype none
module pamx_top_chk (
   input wire logic        i_clk_sys,
   input wire logic        i_nrst,
   input wire logic        i_avs_read,
   input wire logic        i_avs_write,
   input wire logic [31:0] o_avs_readdata,
   input wire logic        o_avs_waitrequest,
   input wire logic [3:0]  i_osc_select_field,
   input wire logic        i_sr_latch_true_output,
   input wire logic        i_sr_true_en,
   input wire logic        i_sr_latch_inverted_output,
   input wire logic        i_sr_inv_en,
   input wire logic        i_comparator_one_output,
   input wire logic        i_cmp1_en,
   input wire logic        i_comparator_two_output,
   input wire logic        i_cmp2_en,
   input wire logic        i_capture_compare_five,
   input wire logic        i_capture_compare_five_en,
   input wire logic [7:0]  o_pin_out,
   input wire logic [7:0]  o_pin_oe
);
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (!i_nrst);
   // -------------------------------------------------------------
   // bus handshake and read data
   // -------------------------------------------------------------
   a_wait_one_cycle: assert property ((i_avs_read || i_avs_write) &&
      o_avs_waitrequest |=> !o_avs_waitrequest ##1 o_avs_waitrequest)
      else $error("waitrequest not low for exactly one cycle");
   a_upper_read_zero: assert property (o_avs_readdata[31:8] == 24'h0)
      else $error("upper read data bits not zero");
   // -------------------------------------------------------------
   // output priority, one cycle behind the sources
   // -------------------------------------------------------------
   a_pin4_sr_wins: assert property ($past(i_sr_true_en) && o_pin_oe[4]
      |-> o_pin_out[4] == $past(i_sr_latch_true_output))
      else $error("pin 4 not driven by sr latch");
   a_pin4_cmp_next: assert property ($past(!i_sr_true_en && i_cmp1_en)
      && o_pin_oe[4] |-> o_pin_out[4] == $past(i_comparator_one_output))
      else $error("pin 4 not driven by comparator one");
   a_pin4_ccp_last: assert property ($past(!i_sr_true_en && !i_cmp1_en
      && i_capture_compare_five_en) && o_pin_oe[4]
      |-> o_pin_out[4] == $past(i_capture_compare_five))
      else $error("pin 4 not driven by capture compare");
   a_pin5_inv_wins: assert property ($past(i_sr_inv_en) && o_pin_oe[5]
      |-> o_pin_out[5] == $past(i_sr_latch_inverted_output))
      else $error("pin 5 not driven by inverted sr output");
   a_pin5_cmp_next: assert property ($past(!i_sr_inv_en && i_cmp2_en)
      && o_pin_oe[5] |-> o_pin_out[5] == $past(i_comparator_two_output))
      else $error("pin 5 not driven by comparator two");
   // -------------------------------------------------------------
   // oscillator pins
   // -------------------------------------------------------------
   a_clkout_quarter: assert property ($rose(o_pin_out[6]) &&
      i_osc_select_field == 4'h1 && $past(o_pin_oe[6], 3) |=> o_pin_out[6]
      ##1 !o_pin_out[6] ##1 !o_pin_out[6] ##1 o_pin_out[6])
      else $error("clock out not a quarter rate square wave");
   a_osc_pin7_quiet: assert property (i_osc_select_field != 4'h3
      |-> !o_pin_oe[7] && (i_osc_select_field != 4'h0 || !o_pin_oe[6]))
      else $error("oscillator pin driven digitally");
   c_clkout: cover property ($rose(o_pin_out[6]) && o_pin_oe[6]);
   c_sr_drive: cover property (i_sr_true_en && o_pin_oe[4]);
   c_read: cover property (i_avs_read && !o_avs_waitrequest);
endmodule
bind pamx_top pamx_top_chk u_chk (.i_clk_sys, .i_nrst, .i_avs_read,
   .i_avs_write, .o_avs_readdata, .o_avs_waitrequest, .i_osc_select_field,
   .i_sr_latch_true_output, .i_sr_true_en, .i_sr_latch_inverted_output,
   .i_sr_inv_en, .i_comparator_one_output, .i_cmp1_en,
   .i_comparator_two_output, .i_cmp2_en, .i_capture_compare_five,
   .i_capture_compare_five_en, .o_pin_out, .o_pin_oe);
`default_nettype wire

// >>> verification/pamx_periph_model.sv
// peripheral sources and pad levels seen at the port a pins
`timescale 1ns/1ns
`default_nettype none
module pamx_periph_model (
   input  wire logic       i_clk_sys,
   input  wire logic [4:0] i_en,
   input  wire logic [4:0] i_val,
   input  wire logic [7:0] i_pad,
   input  wire logic [7:0] i_pin_out,
   input  wire logic [7:0] i_pin_oe,
   output var  logic [4:0] o_src_en,
   output var  logic [4:0] o_src_val,
   output wire logic [7:0] o_pin_in
);
   // sources settle one clock after the request, like real flops
   always @(posedge i_clk_sys) begin
      o_src_en <= i_en;
      o_src_val <= i_val;
   end
   // undriven pin follows the outside level
   assign o_pin_in = (i_pin_oe & i_pin_out) | (~i_pin_oe & i_pad);
endmodule
`default_nettype wire

// >>> verification/pamx_top_tb_top.sv
// self-checking bench for the port a pin function mux
`timescale 1ns/1ns
`default_nettype none
`include "pamx_map.vh"
module pamx_top_tb_top;
   localparam logic [23:0] MTAB = 24'h332210;
   localparam logic [5:0]  CTAB = 6'b100101;
   logic        clk_sys = 1'b0;
   logic        nrst = 1'b0;
   logic [4:0]  addr = 5'h00;
   logic        rd = 1'b0;
   logic        wr = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [3:0]  osc = 4'h0;
   logic        clock_out_function = 1'b0;
   logic [4:0]  en = 5'h00;
   logic [4:0]  val = 5'h00;
   logic [7:0]  pad = 8'h00;
   wire  [31:0] rdata;
   wire         wq, xin, xout, xclk;
   wire  [7:0]  pin_out, pin_oe, pin_in, aen;
   wire  [4:0]  slew, s_en, s_val;
   logic [31:0] expq[$];
   logic [7:0]  lf = 8'h28;
   int          mismatches = 0;
   int          check_count = 0;
   always #4 clk_sys = ~clk_sys;
   pamx_top u_dut (.i_clk_sys(clk_sys), .i_nrst(nrst), .i_avs_address(addr),
      .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata),
      .o_avs_readdata(rdata), .o_avs_waitrequest(wq),
      .i_osc_select_field(osc), .i_clkout_strap(clock_out_function),
      .i_sr_latch_true_output(s_val[0]), .i_sr_true_en(s_en[0]),
      .i_sr_latch_inverted_output(s_val[1]), .i_sr_inv_en(s_en[1]),
      .i_comparator_one_output(s_val[2]), .i_cmp1_en(s_en[2]),
      .i_comparator_two_output(s_val[3]), .i_cmp2_en(s_en[3]),
      .i_capture_compare_five(s_val[4]), .i_capture_compare_five_en(s_en[4]),
      .i_pin_in(pin_in), .o_pin_out(pin_out), .o_pin_oe(pin_oe),
      .o_analog_en(aen), .o_slew_limit(slew),
      .o_crystal_input_function(xin), .o_crystal_output_function(xout),
      .o_external_clock_in_function(xclk));
   pamx_periph_model u_model (.i_clk_sys(clk_sys), .i_en(en), .i_val(val),
      .i_pad(pad), .i_pin_out(pin_out), .i_pin_oe(pin_oe), .o_src_en(s_en),
      .o_src_val(s_val), .o_pin_in(pin_in));
   function automatic logic [7:0] nxt(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   task automatic chk(input string n, input logic [31:0] seen,
                      input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", n, exp, seen);
      end
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // one avalon access; for a read d is the expected data
   task automatic acc(input logic r, input logic [4:0] a,
                      input logic [31:0] d);
      @(posedge clk_sys);
      if (r) expq.push_back(d);
      rd <= r;
      wr <= ~r;
      addr <= a;
      wdata <= d;
      // hold until waitrequest is seen low at a rising edge
      do begin
         @(posedge clk_sys);
      end while (wq !== 1'b0);
      rd <= 1'b0;
      wr <= 1'b0;
   endtask
   always @(posedge clk_sys) begin
      if (rd && wq === 1'b0)
         chk("readdata", rdata, expq.pop_front());
   end
   initial begin
      #100000;
      mismatches++;
      wrap_up();
   end
   initial begin
      logic [3:0] m;
      logic       ce, p;
      logic [7:0] r, ie;
      int         k, rises;
      for (k = 0; k < 6; k++) begin
         @(posedge clk_sys);
         nrst <= 1'b0;
         osc <= MTAB[4*k +: 4];
         clock_out_function <= CTAB[k];
         repeat (3) @(posedge clk_sys);
         nrst <= 1'b1;
         m = osc;
         ce = (m == 4'h1) || (m != 4'h0 && clock_out_function);
         acc(1, `PAMX_OFS_STATUS, {26'h0, 1'b1, clock_out_function, m});
         acc(1, `PAMX_OFS_DIRECTION, 32'hFF);
         acc(1, `PAMX_OFS_SLEW, 32'h0);
         acc(1, 5'h18, 32'h0);
         acc(0, `PAMX_OFS_SLEW, 32'hFF);
         acc(1, `PAMX_OFS_SLEW, 32'h1F);
         chk("slew", {27'h0, slew}, 32'h1F);
         lf = nxt(lf);
         r = lf;
         acc(0, `PAMX_OFS_PIN_LEVEL, {24'h0, r});
         acc(1, `PAMX_OFS_OUT_LATCH, {24'h0, r});
         acc(0, `PAMX_OFS_DIRECTION, 32'h0);
         // pin enables follow the direction write one edge later
         repeat (2) @(negedge clk_sys);
         chk("oe6", pin_oe[6], m != 4'h0 && (ce || m == 4'h3));
         chk("oe7", pin_oe[7], m == 4'h3);
         if (m == 4'h3 && !ce) chk("out6", pin_out[6], r[6]);
         if (m == 4'h3) chk("out7", pin_out[7], r[7]);
         if (ce) begin
            rises = 0;
            p = pin_out[6];
            repeat (16) begin
               @(negedge clk_sys);
               rises += (!p && pin_out[6]);
               p = pin_out[6];
            end
            chk("clock out rises", 32'(rises), 32'd4);
         end
         // bit 5 stays analog here: outputs must still drive it
         repeat (8) begin
            @(posedge clk_sys);
            lf = nxt(lf);
            en <= lf[4:0];
            val <= lf[7:3];
            repeat (2) @(posedge clk_sys);
            @(negedge clk_sys);
            chk("pin4", pin_out[4], en[0] ? val[0] : en[2] ? val[2]
               : en[4] ? val[4] : r[4]);
            chk("pin5", pin_out[5], en[1] ? val[1] : en[3] ? val[3]
               : r[5]);
         end
         @(posedge clk_sys);
         lf = nxt(lf);
         pad <= lf;
         acc(0, `PAMX_OFS_DIRECTION, 32'hFF);
         ie = {m == 4'h3, m == 4'h3 && !ce, 6'h3F};
         acc(0, `PAMX_OFS_ANALOG, 32'h0);
         acc(1, `PAMX_OFS_PIN_LEVEL, {24'h0, pad & ie});
         acc(0, `PAMX_OFS_ANALOG, 32'hFF);
         acc(1, `PAMX_OFS_ANALOG, 32'h2F);
         acc(1, `PAMX_OFS_PIN_LEVEL, {24'h0, pad & ie & 8'hD0});
         @(negedge clk_sys);
         chk("analog_en", {24'h0, aen}, 32'h2F);
         chk("xin", xin, m != 4'h3);
         chk("xclk", xclk, m != 4'h3 && pad[7]);
         chk("xout", xout, m == 4'h0);
      end
      wrap_up();
   end
endmodule
`default_nettype wire
